//--- rtl/axil_cfg_slave.sv
`timescale 1ns/100ps
module axil_cfg_slave (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address and data
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read address and data
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // register bank side
  lane_cfg_if.bus          cfg
);
  typedef enum logic [2:0] {WR_COLLECT = 3'h1, WR_COMMIT = 3'h2, WR_RESP = 3'h4} wr_state_e;
  typedef enum logic [1:0] {RD_IDLE = 2'h1, RD_RESP = 2'h2} rd_state_e;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  wr_state_e   wr_state_ff, nxt_wr_state;
  rd_state_e   rd_state_ff, nxt_rd_state;
  logic        aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [15:0] awaddr_ff, nxt_awaddr;
  logic [7:0]  wdata_ff, nxt_wdata;
  logic        wlane_ff, nxt_wlane;
  logic        awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
  logic        arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  // write channel: collect address and data in either order, commit, answer
  always_comb begin
    nxt_wr_state = wr_state_ff;
    nxt_aw_got   = aw_got_ff;
    nxt_w_got    = w_got_ff;
    nxt_awaddr   = awaddr_ff;
    nxt_wdata    = wdata_ff;
    nxt_wlane    = wlane_ff;
    nxt_bvalid   = bvalid_ff;
    nxt_bresp    = bresp_ff;
    cfg.wr_en    = 1'b0;
    unique case (wr_state_ff)
      WR_COLLECT: begin
        if (awvalid && awready_ff) begin
          nxt_awaddr = awaddr;
          nxt_aw_got = 1'b1;
        end
        if (wvalid && wready_ff) begin
          nxt_wdata = wdata[7:0];
          nxt_wlane = wstrb[0];
          nxt_w_got = 1'b1;
        end
        if (nxt_aw_got && nxt_w_got) nxt_wr_state = WR_COMMIT;
      end
      WR_COMMIT: begin
        cfg.wr_en    = 1'b1;
        nxt_aw_got   = 1'b0;
        nxt_w_got    = 1'b0;
        nxt_bvalid   = 1'b1;
        nxt_bresp    = (lane_cfg_pkg::decode_addr(awaddr_ff) == lane_cfg_pkg::SEL_NONE) ?
                       RESP_SLVERR : RESP_OKAY;
        nxt_wr_state = WR_RESP;
      end
      WR_RESP: begin
        if (bready) begin
          nxt_bvalid   = 1'b0;
          nxt_wr_state = WR_COLLECT;
        end
      end
    endcase
    nxt_awready = (nxt_wr_state == WR_COLLECT) && !nxt_aw_got;
    nxt_wready  = (nxt_wr_state == WR_COLLECT) && !nxt_w_got;
  end

  // read channel: one-cycle lookup, answer held until taken
  always_comb begin
    nxt_rd_state = rd_state_ff;
    nxt_rvalid   = rvalid_ff;
    nxt_rdata    = rdata_ff;
    nxt_rresp    = rresp_ff;
    unique case (rd_state_ff)
      RD_IDLE: begin
        if (arvalid && arready_ff) begin
          nxt_rdata    = cfg.rd_data;
          nxt_rresp    = (lane_cfg_pkg::decode_addr(araddr) == lane_cfg_pkg::SEL_NONE) ?
                         RESP_SLVERR : RESP_OKAY;
          nxt_rvalid   = 1'b1;
          nxt_rd_state = RD_RESP;
        end
      end
      RD_RESP: begin
        if (rready) begin
          nxt_rvalid   = 1'b0;
          nxt_rd_state = RD_IDLE;
        end
      end
    endcase
    nxt_arready = (nxt_rd_state == RD_IDLE);
  end

  // channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= WR_COLLECT;
      rd_state_ff <= RD_IDLE;
      aw_got_ff   <= 1'b0;
      w_got_ff    <= 1'b0;
      awaddr_ff   <= 16'h0000;
      wdata_ff    <= 8'h00;
      wlane_ff    <= 1'b0;
      awready_ff  <= 1'b1;
      wready_ff   <= 1'b1;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= 2'h0;
      arready_ff  <= 1'b1;
      rvalid_ff   <= 1'b0;
      rresp_ff    <= 2'h0;
      rdata_ff    <= 32'h0000_0000;
    end else begin
      wr_state_ff <= nxt_wr_state;
      rd_state_ff <= nxt_rd_state;
      aw_got_ff   <= nxt_aw_got;
      w_got_ff    <= nxt_w_got;
      awaddr_ff   <= nxt_awaddr;
      wdata_ff    <= nxt_wdata;
      wlane_ff    <= nxt_wlane;
      awready_ff  <= nxt_awready;
      wready_ff   <= nxt_wready;
      bvalid_ff   <= nxt_bvalid;
      bresp_ff    <= nxt_bresp;
      arready_ff  <= nxt_arready;
      rvalid_ff   <= nxt_rvalid;
      rresp_ff    <= nxt_rresp;
      rdata_ff    <= nxt_rdata;
    end
  end

  // bank side and bus outputs
  assign cfg.wr_addr    = awaddr_ff;
  assign cfg.wr_data    = wdata_ff;
  assign cfg.wr_lane_en = wlane_ff;
  assign cfg.rd_addr    = araddr;
  assign awready        = awready_ff;
  assign wready         = wready_ff;
  assign bvalid         = bvalid_ff;
  assign bresp          = bresp_ff;
  assign arready        = arready_ff;
  assign rvalid         = rvalid_ff;
  assign rresp          = rresp_ff;
  assign rdata          = rdata_ff;
endmodule : axil_cfg_slave

//--- rtl/lane_cfg_if.sv
`timescale 1ns/100ps
// register access strobes between the bus slave and the register bank
interface lane_cfg_if;
  logic        wr_en;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic        wr_lane_en;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;

  modport bus  (output wr_en, wr_addr, wr_data, wr_lane_en, rd_addr, input rd_data);
  modport bank (input wr_en, wr_addr, wr_data, wr_lane_en, rd_addr, output rd_data);
endinterface : lane_cfg_if

//--- rtl/lane_cfg_pkg.sv
package lane_cfg_pkg;
  `include "lane_cfg_regs.svh"

  typedef logic [`SWING_W-1:0] swing_code_t;

  // documented swing codes, fraction of the lane driver supply
  typedef enum logic [`SWING_W-1:0] {
    SWING_FULL = 3'h0,
    SWING_0850 = 3'h1,
    SWING_0750 = 3'h2
  } swing_level_e;

  // decoded register selection
  typedef enum logic [6:0] {
    SEL_NONE   = 7'h01,
    SEL_INVERT = 7'h02,
    SEL_SW01   = 7'h04,
    SEL_SW23   = 7'h08,
    SEL_SW45   = 7'h10,
    SEL_SW67   = 7'h20,
    SEL_STATUS = 7'h40
  } reg_sel_e;

  // word-aligned byte address to register selection
  function automatic reg_sel_e decode_addr(input logic [15:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[13:2])
        `IDX_LANE_INVERT:   sel = SEL_INVERT;
        `IDX_LANE_SWING_01: sel = SEL_SW01;
        `IDX_LANE_SWING_23: sel = SEL_SW23;
        `IDX_LANE_SWING_45: sel = SEL_SW45;
        `IDX_LANE_SWING_67: sel = SEL_SW67;
        `IDX_LANE_STATUS:   sel = SEL_STATUS;
        default:            sel = SEL_NONE;
      endcase
      if (addr[15:14] != 2'h0) sel = SEL_NONE;
    end
    return sel;
  endfunction : decode_addr

  // true when a swing code is one of the documented levels
  function automatic logic swing_known(input swing_code_t code);
    return (code == SWING_FULL) || (code == SWING_0850) || (code == SWING_0750);
  endfunction : swing_known
endpackage : lane_cfg_pkg

//--- rtl/lane_cfg_regs.svh
`ifndef LANE_CFG_REGS_SVH
`define LANE_CFG_REGS_SVH

// register indices; the byte address is four times the index
`define IDX_LANE_INVERT      12'h5bf
`define IDX_LANE_SWING_01    12'h5c0
`define IDX_LANE_SWING_23    12'h5c1
`define IDX_LANE_SWING_45    12'h5c2
`define IDX_LANE_SWING_67    12'h5c3
`define IDX_LANE_STATUS      12'h5d0

// field positions inside a register, up to bit 8
`define SWING_LO_LSB         0
`define SWING_HI_LSB         4
`define SWING_W              3
`define INVERT_W             4
`define STAT_RSVD_WR_BIT     8

// reset values
`define SWING_RESET          3'h1
`define INVERT_RESET         4'h0

`endif

//--- rtl/lane_polarity.sv
`timescale 1ns/100ps
module lane_polarity #(
  parameter int LANES  = 8,
  parameter int WORD_W = 8
) (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // lane words and per-lane invert mask
  input  wire logic [LANES-1:0][WORD_W-1:0]  word_in,
  input  wire logic [LANES-1:0]              invert,
  output logic      [LANES-1:0][WORD_W-1:0]  word_out
);
  logic [LANES-1:0][WORD_W-1:0] word_ff, nxt_word;

  // flip every bit of a lane whose invert bit is set
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      nxt_word[i] = invert[i] ? ~word_in[i] : word_in[i];
    end
  end

  // output stage
  always_ff @(posedge aclk) begin
    if (!aresetn) word_ff <= '0;
    else          word_ff <= nxt_word;
  end

  assign word_out = word_ff;
endmodule : lane_polarity

//--- rtl/serial_lane_output_config.sv
// Operation
// - lane 0 swing, 0x05C0 bits 2:0, reset 1
// - lane 1 swing, 0x05C0 bits 6:4, reset 1
// - lane 2 swing, 0x05C1 bits 2:0, reset 1
// - lane 3 swing, 0x05C1 bits 6:4, reset 1
// - lane 4 swing, 0x05C2 bits 2:0, reset 1
// - lane 5 swing, 0x05C2 bits 6:4, reset 1
// - lane 7 swing 0x05C3[6:4]; bits 7,3 zero
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "lane_cfg_regs.svh"
module serial_lane_output_config #(
  parameter int LANES  = 8,
  parameter int WORD_W = 8
) (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite write address and data
  input  wire logic [15:0]                   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read
  input  wire logic [15:0]                   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // serialized lane words before and after polarity control
  input  wire logic [LANES-1:0][WORD_W-1:0]  lane_word_in,
  output logic      [LANES-1:0][WORD_W-1:0]  output_lane_word,
  // swing codes to the lane drivers
  output lane_cfg_pkg::swing_code_t [LANES-1:0] output_lane_swing
);
  lane_cfg_if cfg ();

  // lane 6 swing lives outside this bank; its slot holds the default code
  localparam int LANE_6 = 6;

  lane_cfg_pkg::swing_code_t [LANES-1:0] swing_ff, nxt_swing;
  logic [`INVERT_W-1:0]                  invert_ff, nxt_invert;
  logic [LANES-1:0]                      odd_code_ff, nxt_odd_code;
  logic                                  rsvd_wr_ff, nxt_rsvd_wr;
  logic [LANES-1:0]                      invert_mask;
  lane_cfg_pkg::reg_sel_e                wr_sel;
  lane_cfg_pkg::reg_sel_e                rd_sel;
  logic                                  wr_hit;
  logic                                  rsvd_touch;

  // bus slave in front of the register bank
  axil_cfg_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .cfg     (cfg.bus)
  );

  // decode of the committed write and of the read request
  assign wr_sel = lane_cfg_pkg::decode_addr(cfg.wr_addr);
  assign rd_sel = lane_cfg_pkg::decode_addr(cfg.rd_addr);
  assign wr_hit = cfg.wr_en && cfg.wr_lane_en;

  // swing and invert fields take the low byte of a committed write
  always_comb begin
    nxt_swing  = swing_ff;
    nxt_invert = invert_ff;
    rsvd_touch = 1'b0;
    if (wr_hit) begin
      unique case (wr_sel)
        lane_cfg_pkg::SEL_SW01: begin
          nxt_swing[0] = cfg.wr_data[`SWING_LO_LSB +: `SWING_W];
          nxt_swing[1] = cfg.wr_data[`SWING_HI_LSB +: `SWING_W];
          rsvd_touch   = cfg.wr_data[7] | cfg.wr_data[3];
        end
        lane_cfg_pkg::SEL_SW23: begin
          nxt_swing[2] = cfg.wr_data[`SWING_LO_LSB +: `SWING_W];
          nxt_swing[3] = cfg.wr_data[`SWING_HI_LSB +: `SWING_W];
          rsvd_touch   = cfg.wr_data[7] | cfg.wr_data[3];
        end
        lane_cfg_pkg::SEL_SW45: begin
          nxt_swing[4] = cfg.wr_data[`SWING_LO_LSB +: `SWING_W];
          nxt_swing[5] = cfg.wr_data[`SWING_HI_LSB +: `SWING_W];
          rsvd_touch   = cfg.wr_data[7] | cfg.wr_data[3];
        end
        lane_cfg_pkg::SEL_SW67: begin
          // low field belongs to lane 6, handled elsewhere
          nxt_swing[7] = cfg.wr_data[`SWING_HI_LSB +: `SWING_W];
          rsvd_touch   = cfg.wr_data[7] | cfg.wr_data[3];
        end
        lane_cfg_pkg::SEL_INVERT: begin
          nxt_invert = cfg.wr_data[`INVERT_W-1:0];
        end
        lane_cfg_pkg::SEL_STATUS: begin
          rsvd_touch = 1'b0;
        end
        lane_cfg_pkg::SEL_NONE: begin
          rsvd_touch = 1'b0;
        end
      endcase
    end
  end

  // status: undocumented swing codes and a sticky reserved-write flag
  always_comb begin
    nxt_odd_code = '0;
    for (int i = 0; i < LANES; i++) begin
      if (i != LANE_6) nxt_odd_code[i] = !lane_cfg_pkg::swing_known(nxt_swing[i]);
    end
    nxt_rsvd_wr = rsvd_wr_ff;
    // writing 1 to status bit 0 clears the flag, a new event in the same cycle wins
    if (wr_hit && (wr_sel == lane_cfg_pkg::SEL_STATUS) && cfg.wr_data[0]) begin
      nxt_rsvd_wr = 1'b0;
    end
    if (rsvd_touch) nxt_rsvd_wr = 1'b1;
  end

  // register bank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LANES; i++) begin
        swing_ff[i] <= `SWING_RESET;
      end
      invert_ff   <= `INVERT_RESET;
      odd_code_ff <= '0;
      rsvd_wr_ff  <= 1'b0;
    end else begin
      swing_ff    <= nxt_swing;
      invert_ff   <= nxt_invert;
      odd_code_ff <= nxt_odd_code;
      rsvd_wr_ff  <= nxt_rsvd_wr;
    end
  end

  // read mux; reserved bits and the lane 6 field read as zero
  always_comb begin
    cfg.rd_data = 32'h0000_0000;
    unique case (rd_sel)
      lane_cfg_pkg::SEL_SW01: begin
        cfg.rd_data[`SWING_LO_LSB +: `SWING_W] = swing_ff[0];
        cfg.rd_data[`SWING_HI_LSB +: `SWING_W] = swing_ff[1];
      end
      lane_cfg_pkg::SEL_SW23: begin
        cfg.rd_data[`SWING_LO_LSB +: `SWING_W] = swing_ff[2];
        cfg.rd_data[`SWING_HI_LSB +: `SWING_W] = swing_ff[3];
      end
      lane_cfg_pkg::SEL_SW45: begin
        cfg.rd_data[`SWING_LO_LSB +: `SWING_W] = swing_ff[4];
        cfg.rd_data[`SWING_HI_LSB +: `SWING_W] = swing_ff[5];
      end
      lane_cfg_pkg::SEL_SW67: begin
        cfg.rd_data[`SWING_HI_LSB +: `SWING_W] = swing_ff[7];
      end
      lane_cfg_pkg::SEL_INVERT: begin
        cfg.rd_data[`INVERT_W-1:0] = invert_ff;
      end
      lane_cfg_pkg::SEL_STATUS: begin
        cfg.rd_data[LANES-1:0]         = odd_code_ff;
        cfg.rd_data[`STAT_RSVD_WR_BIT] = rsvd_wr_ff;
      end
      lane_cfg_pkg::SEL_NONE: begin
        cfg.rd_data = 32'h0000_0000;
      end
    endcase
  end

  // invert only applies to lanes 0 to 3; upper lanes pass straight
  always_comb begin
    invert_mask = '0;
    invert_mask[`INVERT_W-1:0] = invert_ff;
  end

  // polarity stage on the serialized lane words
  lane_polarity #(
    .LANES  (LANES),
    .WORD_W (WORD_W)
  ) u_polarity (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .word_in  (lane_word_in),
    .invert   (invert_mask),
    .word_out (output_lane_word)
  );

  // swing codes leave straight from the bank flip-flops
  assign output_lane_swing = swing_ff;
endmodule : serial_lane_output_config

//--- testbench/lane_out_chk.sv
`timescale 1ns/100ps
module lane_out_chk #(
  parameter int LANES  = 8,
  parameter int WORD_W = 8
) (
  // clock and reset
  input wire logic                                aclk,
  input wire logic                                aresetn,
  // write channels
  input wire logic [15:0]                         s_axi_awaddr,
  input wire logic                                s_axi_awvalid,
  input wire logic                                s_axi_awready,
  input wire logic [31:0]                         s_axi_wdata,
  input wire logic [3:0]                          s_axi_wstrb,
  input wire logic                                s_axi_wvalid,
  input wire logic                                s_axi_wready,
  input wire logic [1:0]                          s_axi_bresp,
  input wire logic                                s_axi_bvalid,
  input wire logic                                s_axi_bready,
  // read channels
  input wire logic [15:0]                         s_axi_araddr,
  input wire logic                                s_axi_arvalid,
  input wire logic                                s_axi_arready,
  input wire logic [31:0]                         s_axi_rdata,
  input wire logic [1:0]                          s_axi_rresp,
  input wire logic                                s_axi_rvalid,
  input wire logic                                s_axi_rready,
  // lane words and swing codes
  input wire logic [LANES-1:0][WORD_W-1:0]        lane_word_in,
  input wire logic [LANES-1:0][WORD_W-1:0]        output_lane_word,
  input wire lane_cfg_pkg::swing_code_t [LANES-1:0] output_lane_swing
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // captured request fields and delayed copies
  logic [15:0]                  aw_q;
  logic [15:0]                  ar_q;
  logic [7:0]                   wd_q;
  logic                         ws_q;
  logic                         bv_q;
  logic                         rst_q;
  logic [3:0]                   inv_q;
  logic [LANES-1:0][WORD_W-1:0] in_q;
  logic [3:0][WORD_W-1:0]       lo_q;
  wire                          wr_new  = s_axi_bvalid && !bv_q && ws_q;
  wire                          inv_wr  = wr_new && aw_q == 16'h16fc;
  wire  [3:0]                   inv_eff = inv_wr ? wd_q[3:0] : inv_q;

  // track accepted requests and the expected lane words
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) begin
      wd_q <= s_axi_wdata[7:0];
      ws_q <= s_axi_wstrb[0];
    end
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    bv_q  <= s_axi_bvalid;
    rst_q <= aresetn;
    in_q  <= lane_word_in;
    inv_q <= aresetn ? inv_eff : 4'h0;
    for (int i = 0; i < 4; i++) lo_q[i] <= lane_word_in[i] ^ {WORD_W{inv_eff[i]}};
  end

  property p_l0_swing; wr_new && aw_q == 16'h1700 |-> output_lane_swing[0] == wd_q[2:0]; endproperty
  a_l0_swing: assert property (p_l0_swing) else $error("lane 0 swing wrong");
  property p_l1_swing; wr_new && aw_q == 16'h1700 |-> output_lane_swing[1] == wd_q[6:4]; endproperty
  a_l1_swing: assert property (p_l1_swing) else $error("lane 1 swing wrong");
  property p_l2_swing; wr_new && aw_q == 16'h1704 |-> output_lane_swing[2] == wd_q[2:0]; endproperty
  a_l2_swing: assert property (p_l2_swing) else $error("lane 2 swing wrong");
  property p_l3_swing; wr_new && aw_q == 16'h1704 |-> output_lane_swing[3] == wd_q[6:4]; endproperty
  a_l3_swing: assert property (p_l3_swing) else $error("lane 3 swing wrong");
  property p_l4_swing; wr_new && aw_q == 16'h1708 |-> output_lane_swing[4] == wd_q[2:0]; endproperty
  a_l4_swing: assert property (p_l4_swing) else $error("lane 4 swing wrong");
  property p_l5_swing; wr_new && aw_q == 16'h1708 |-> output_lane_swing[5] == wd_q[6:4]; endproperty
  a_l5_swing: assert property (p_l5_swing) else $error("lane 5 swing wrong");
  property p_l7_swing; wr_new && aw_q == 16'h170c |-> output_lane_swing[7] == wd_q[6:4]; endproperty
  a_l7_swing: assert property (p_l7_swing) else $error("lane 7 swing wrong");
  property p_rsvd_rd;
    s_axi_rvalid && ar_q[15:4] == 12'h170 |-> s_axi_rdata[31:7] == 25'h0 && !s_axi_rdata[3];
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bits read nonzero");
  property p_rst_val;
    $rose(aresetn) |-> output_lane_swing == {LANES{3'h1}} && output_lane_word == '0;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
  property p_inv_lo; rst_q |-> output_lane_word[3:0] == lo_q; endproperty
  a_inv_lo: assert property (p_inv_lo) else $error("lanes 0 to 3 polarity wrong");
  property p_pass_hi; rst_q |-> output_lane_word[7:4] == in_q[7:4]; endproperty
  a_pass_hi: assert property (p_pass_hi) else $error("lanes 4 to 7 altered");

  // main scenarios reached
  c_inv_wr: cover property (inv_wr && wd_q[3:0] == 4'hf);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : lane_out_chk

//--- testbench/tb.sv
`timescale 1ns/100ps
module tb;
  // stimulus
  logic                         aclk          = 1'b0;
  logic                         aresetn       = 1'b0;
  logic [15:0]                  s_axi_awaddr  = 16'h0;
  logic                         s_axi_awvalid = 1'b0;
  logic [31:0]                  s_axi_wdata   = 32'h0;
  logic [3:0]                   s_axi_wstrb   = 4'h0;
  logic                         s_axi_wvalid  = 1'b0;
  logic                         s_axi_bready  = 1'b0;
  logic [15:0]                  s_axi_araddr  = 16'h0;
  logic                         s_axi_arvalid = 1'b0;
  logic                         s_axi_rready  = 1'b0;
  logic [7:0][7:0]              lane_word_in  = 64'h0;
  // design outputs
  logic                         s_axi_awready;
  logic                         s_axi_wready;
  logic [1:0]                   s_axi_bresp;
  logic                         s_axi_bvalid;
  logic                         s_axi_arready;
  logic [31:0]                  s_axi_rdata;
  logic [1:0]                   s_axi_rresp;
  logic                         s_axi_rvalid;
  logic [7:0][7:0]              output_lane_word;
  lane_cfg_pkg::swing_code_t [7:0] output_lane_swing;
  // bookkeeping
  int                           bad_count     = 0;
  int                           compares      = 0;
  int                           cyc           = 0;

  serial_lane_output_config dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lane_word_in, .output_lane_word,
    .output_lane_swing
  );

  // clock
  always #2 aclk = ~aclk;

  // cycle ceiling against hangs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // one write, address and data offered together
  task automatic axi_write(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : axi_write

  task automatic rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(name, s_axi_rdata, exp);
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd_chk

  // drive one word per lane and compare the registered result
  task automatic lane_chk(input logic [3:0] inv);
    logic [7:0][7:0] p;
    for (int i = 0; i < 8; i++) p[i] = 8'h5a ^ {inv, 1'b0, 3'(i)};
    @(posedge aclk);
    lane_word_in <= p;
    @(posedge aclk);
    #1;
    for (int i = 0; i < 8; i++)
      check("lane_word", {24'h0, output_lane_word[i]},
            {24'h0, ((i < 4) && inv[i[1:0]]) ? ~p[i] : p[i]});
  endtask : lane_chk

  task automatic chk_swing(input logic [7:0][2:0] ex);
    for (int i = 0; i < 8; i++)
      check("swing", {29'h0, output_lane_swing[i]}, {29'h0, ex[i]});
  endtask : chk_swing

  task automatic chk_reset();
    rd_chk("invert", 16'h16fc, 32'h0, 2'h0);
    for (int k = 0; k < 3; k++)
      rd_chk("swing_reg", 16'h1700 + 16'(4 * k), 32'h11, 2'h0);
    rd_chk("swing_reg", 16'h170c, 32'h10, 2'h0);
    rd_chk("status", 16'h1740, 32'h0, 2'h0);
    chk_swing({8{3'h1}});
    lane_chk(4'h0);
  endtask : chk_reset

  // main sequence
  initial begin
    logic [7:0][2:0] ex;
    logic [7:0]      d;
    logic [2:0]      lo;
    logic [2:0]      hi;
    ex = {8{3'h1}};
    do_reset();
    chk_reset();
    // every documented code in every field, reserved bits set on write
    for (int n = 0; n < 3; n++) begin
      for (int k = 0; k < 4; k++) begin
        lo = 3'(n);
        hi = 3'((n + 1) % 3);
        d  = {1'b1, hi, 1'b1, lo};
        if (k < 3) ex[2 * k] = lo;
        ex[2 * k + 1] = hi;
        axi_write(16'h1700 + 16'(4 * k), d, 4'hf, 2'h0);
        rd_chk("swing_reg", 16'h1700 + 16'(4 * k), {24'h0, d & ((k == 3) ? 8'h70 : 8'h77)},
               2'h0);
        chk_swing(ex);
      end
    end
    // strobe off, unmapped and misaligned writes change nothing
    axi_write(16'h1700, 8'h00, 4'h0, 2'h0);
    axi_write(16'h5700, 8'h00, 4'hf, 2'h2);
    axi_write(16'h1701, 8'h00, 4'hf, 2'h2);
    rd_chk("swing_reg", 16'h1700, 32'h02, 2'h0);
    rd_chk("unmapped", 16'h5700, 32'h0, 2'h2);
    rd_chk("misaligned", 16'h1702, 32'h0, 2'h2);
    chk_swing(ex);
    // sticky reserved-write flag is set, then cleared by writing one
    rd_chk("status", 16'h1740, 32'h100, 2'h0);
    axi_write(16'h1740, 8'h01, 4'hf, 2'h0);
    rd_chk("status", 16'h1740, 32'h0, 2'h0);
    // polarity control
    axi_write(16'h16fc, 8'hff, 4'hf, 2'h0);
    rd_chk("invert", 16'h16fc, 32'h0f, 2'h0);
    lane_chk(4'hf);
    axi_write(16'h16fc, 8'h05, 4'hf, 2'h0);
    rd_chk("invert", 16'h16fc, 32'h05, 2'h0);
    lane_chk(4'h5);
    // an undocumented code is stored as written and flagged in status
    axi_write(16'h1704, 8'h07, 4'hf, 2'h0);
    rd_chk("swing_reg", 16'h1704, 32'h07, 2'h0);
    rd_chk("status", 16'h1740, 32'h04, 2'h0);
    // reset in mid-run restores defaults
    do_reset();
    chk_reset();
    complete_run();
  end
endmodule : tb

bind serial_lane_output_config lane_out_chk #(.LANES(LANES), .WORD_W(WORD_W)) chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lane_word_in, .output_lane_word,
  .output_lane_swing
);
